// >>> core/pcie_cap_cfg_pkg.sv
// constants, field layouts and carrier types for the capability configuration registers
package pcie_cap_cfg_pkg;

    // configuration space byte offsets
    localparam logic [11:0] OFS_INTX_LINE  = 12'h03c; // interrupt line / pin dword
    localparam logic [11:0] OFS_MSI_CTRL   = 12'h050; // msi capability header and message control
    localparam logic [11:0] OFS_MSIX_CTRL  = 12'h068; // msi-x capability header and message control
    localparam logic [11:0] OFS_MSIX_TABLE = 12'h06c; // msi-x table offset and indicator
    localparam logic [11:0] OFS_MSIX_PBA   = 12'h070; // msi-x pending array offset and indicator
    localparam logic [11:0] OFS_DEV_CAPS   = 12'h084; // device capabilities
    localparam logic [11:0] OFS_LINK_CAPS  = 12'h090; // link capabilities

    // capability identifiers
    localparam logic [7:0] CAP_ID_MSI  = 8'h05; // msi capability id
    localparam logic [7:0] CAP_ID_MSIX = 8'h11; // msi-x capability id

    // field positions
    localparam int MSI_EN_BIT      = 16; // msi enable
    localparam int MSI_MMC_LSB     = 17; // multiple message capable [19:17]
    localparam int MSI_MME_LSB     = 20; // multiple message enable [22:20]
    localparam int MSIX_SIZE_LSB   = 16; // table size [26:16]
    localparam int MSIX_FMASK_BIT  = 30; // function mask
    localparam int MSIX_EN_BIT     = 31; // msi-x enable
    localparam int FLR_CAP_BIT     = 28; // function level reset capable
    localparam int SURPRISE_BIT    = 19; // surprise down reporting capable
    localparam int DLL_ACTIVE_BIT  = 20; // data link layer active reporting capable
    localparam int INTX_PIN_LSB    = 8;  // interrupt pin byte [15:8]
    localparam int BIR_W           = 3;  // width of a bar indicator
    localparam int MSIX_SIZE_W     = 11; // width of the table size field
    localparam int CODE_W          = 3;  // width of the message and pin code fields
    localparam int MSI_CTRL_LANE   = 2;  // byte lane carrying msi enable and mme
    localparam int MSIX_CTRL_LANE  = 3;  // byte lane carrying msi-x enable and mask

    localparam logic [2:0]  BIR_MAX       = 3'h5;   // highest legal bar indicator
    localparam logic [31:0] QWORD_MASK    = 32'hffff_fff8; // clears the indicator bits
    localparam logic [31:0] RD_ZERO       = 32'h0000_0000; // unmapped read value

    // legacy interrupt choices, encoded as the interrupt pin value
    typedef enum logic [2:0] {
        INTX_NONE = 3'b000,
        INTX_A    = 3'b001,
        INTX_B    = 3'b010,
        INTX_C    = 3'b011,
        INTX_D    = 3'b100
    } intx_sel_t;

    // configuration request from the link side
    typedef struct packed {
        logic        valid; // request present this cycle
        logic        write; // 1 write, 0 read
        logic [11:0] addr;  // byte address, low two bits ignored
        logic [3:0]  be;    // byte enables
        logic [31:0] wdata; // write data
    } cfg_req_t;

    // encode requested message count into the capable field
    function automatic logic [2:0] msi_count_code(input logic [4:0] count);
        case (count)
            5'd1:    msi_count_code = 3'h0;
            5'd2:    msi_count_code = 3'h1;
            5'd4:    msi_count_code = 3'h2;
            5'd8:    msi_count_code = 3'h3;
            5'd16:   msi_count_code = 3'h4;
            default: msi_count_code = 3'h0; // illegal counts fall back to one message
        endcase
    endfunction : msi_count_code

endpackage : pcie_cap_cfg_pkg

// >>> core/pcie_capability_config_regs.sv
// capability configuration registers of one pci express function
// Behaviour
// - flr option sets device capability bit
// - flr option ignored for root port
// - root port advertises dl_active reporting
// - root port advertises surprise down reporting
// - msi count encoded into capable field
// - msi-x structure present only when enabled
// - msi-x table size eleven bits, n-1
// - table offset qword aligned, low bits zero
// - table bar indicator three bits, 0-5
// - pending array offset qword aligned
// - pending array bar indicator three bits, 0-5
// - legacy interrupt selects inta-intd or none
`timescale 1ns/1ps
`default_nettype none
module pcie_capability_config_regs
    import pcie_cap_cfg_pkg::*;
#(
    parameter logic        ROOT_PORT        = 1'b0,      // 1 root port, 0 endpoint
    parameter logic        FLR_ENABLE       = 1'b0,      // function level reset option
    parameter logic        DLL_ACTIVE_EN    = 1'b0,      // data link layer active reporting option
    parameter logic        SURPRISE_DOWN_EN = 1'b0,      // surprise down reporting option
    parameter logic [4:0]  MSI_MESSAGES     = 5'd1,      // 1, 2, 4, 8 or 16
    parameter logic        MSIX_IMPL        = 1'b0,      // implement msi-x
    parameter logic [10:0] MSIX_TABLE_SIZE  = 11'h000,   // entries minus one
    parameter logic [31:0] MSIX_TABLE_OFS   = 32'h0000_0000, // table offset
    parameter logic [2:0]  MSIX_TABLE_BIR   = 3'h0,      // table bar indicator
    parameter logic [31:0] MSIX_PBA_OFS     = 32'h0000_0000, // pending array offset
    parameter logic [2:0]  MSIX_PBA_BIR     = 3'h0,      // pending array bar indicator
    parameter intx_sel_t   INTX_SEL         = INTX_A     // legacy interrupt choice
) (
    input  wire logic        core_clk,     // core clock, 20 mhz
    input  wire logic        arst_n,       // asynchronous reset, active low
    input  wire cfg_req_t    cfg_req,      // configuration request
    output logic [31:0]      cfg_rdata,    // read data
    output logic             cfg_rvalid,   // read data valid, one cycle
    output logic             msi_enable,   // msi enabled by software
    output logic [2:0]       msi_mme,      // msi messages enabled code
    output logic             msix_enable,  // msi-x enabled by software
    output logic             msix_fmask,   // msi-x function masked
    output logic [2:0]       intx_pin      // legacy interrupt pin code
);

    // field values, computed from the settings and, in the two control dwords, from the control flops
    logic        flr_cap;       // function level reset capable
    logic        dll_cap;       // dl_active reporting capable
    logic        sdn_cap;       // surprise down capable
    logic [2:0]  mmc_code;      // multiple message capable code
    logic [2:0]  tbl_bir;       // table indicator, clamped legal
    logic [2:0]  pba_bir;       // pending indicator, clamped legal
    logic [31:0] tbl_word;      // table offset word
    logic [31:0] pba_word;      // pending array word
    logic [31:0] msi_word;      // msi control dword
    logic [31:0] msix_word;     // msi-x control dword
    logic [31:0] dev_word;      // device capabilities dword
    logic [31:0] link_word;     // link capabilities dword
    logic [31:0] intx_word;     // interrupt pin dword

    // software-writable state and read port
    logic        msi_en_q,   msi_en_d;   // msi enable
    logic [2:0]  mme_q,      mme_d;      // messages enabled
    logic        msix_en_q,  msix_en_d;  // msi-x enable
    logic        fmask_q,    fmask_d;    // function mask
    logic [31:0] rdata_q,    rdata_d;    // read data
    logic        rvalid_q,   rvalid_d;   // read strobe
    logic [2:0]  pin_q,      pin_d;      // interrupt pin code
    logic [11:0] dw_addr;                // dword aligned address

    // dword map for configuration reads; every other dword reads zero
    //   0x03c  [10:8]   legacy interrupt pin code
    //   0x050  [7:0]    msi capability id, next pointer zero
    //          [16]     msi enable, written through byte lane 2
    //          [19:17]  multiple message capable, log2 of the count
    //          [22:20]  multiple message enable, clamped to capable
    //   0x068  [7:0]    msi-x capability id, next pointer zero
    //          [26:16]  table size, entries minus one
    //          [30]     function mask, written through byte lane 3
    //          [31]     msi-x enable, written through byte lane 3
    //   0x06c  [31:3]   table offset, qword aligned
    //          [2:0]    table bar indicator
    //   0x070  [31:3]   pending array offset, qword aligned
    //          [2:0]    pending array bar indicator
    //   0x084  [28]     function level reset capable
    //   0x090  [20]     dl_active reporting capable
    //          [19]     surprise down reporting capable
    // limitation: next pointers are zero, so the structures do not form a chain

    // build-time fields; flr only on endpoints, link reporting only on root ports
    // every value here except the msi and msi-x control dwords folds to a constant, so it costs only read mux inputs
    always_comb begin
        flr_cap  = FLR_ENABLE & ~ROOT_PORT;
        dll_cap  = DLL_ACTIVE_EN & ROOT_PORT;
        sdn_cap  = SURPRISE_DOWN_EN & ROOT_PORT;
        // an illegal count advertises one message rather than a bogus code
        mmc_code = msi_count_code(MSI_MESSAGES);
        // an out-of-range indicator would point past the last bar, so it reads as bar 0
        tbl_bir  = (MSIX_TABLE_BIR > BIR_MAX) ? 3'h0 : MSIX_TABLE_BIR;
        pba_bir  = (MSIX_PBA_BIR > BIR_MAX) ? 3'h0 : MSIX_PBA_BIR;
        tbl_word = (MSIX_TABLE_OFS & QWORD_MASK) | {29'h0, tbl_bir};
        pba_word = (MSIX_PBA_OFS & QWORD_MASK) | {29'h0, pba_bir};

        // msi dword: id byte, zero next pointer, enable, capable, enabled
        msi_word = {24'h0, CAP_ID_MSI};
        msi_word[MSI_EN_BIT] = msi_en_q;
        msi_word[MSI_MMC_LSB +: CODE_W] = mmc_code;
        msi_word[MSI_MME_LSB +: CODE_W] = mme_q;

        // msi-x dword: id byte, zero next pointer, size, mask, enable
        msix_word = {24'h0, CAP_ID_MSIX};
        msix_word[MSIX_SIZE_LSB +: MSIX_SIZE_W] = MSIX_TABLE_SIZE;
        msix_word[MSIX_FMASK_BIT] = fmask_q;
        msix_word[MSIX_EN_BIT] = msix_en_q;

        // capability dwords carry only the bits this block owns
        dev_word = RD_ZERO;
        dev_word[FLR_CAP_BIT] = flr_cap;
        link_word = RD_ZERO;
        link_word[DLL_ACTIVE_BIT] = dll_cap;
        link_word[SURPRISE_BIT] = sdn_cap;
        intx_word = RD_ZERO;
        intx_word[INTX_PIN_LSB +: CODE_W] = INTX_SEL;
        pin_d = INTX_SEL;
    end

    // read decode and runtime control writes
    // a write lands at its taking edge, so a read in the next cycle already sees it
    always_comb begin
        dw_addr   = {cfg_req.addr[11:2], 2'b00};
        msi_en_d  = msi_en_q;
        mme_d     = mme_q;
        msix_en_d = msix_en_q;
        fmask_d   = fmask_q;
        rdata_d   = rdata_q;
        rvalid_d  = 1'b0;
        // one command per cycle: a request is either a read or a write
        if (cfg_req.valid && !cfg_req.write) begin
            rvalid_d = 1'b1;
            case (dw_addr)
                OFS_INTX_LINE:  rdata_d = intx_word;
                OFS_MSI_CTRL:   rdata_d = msi_word;
                // without msi-x the whole structure reads as absent
                OFS_MSIX_CTRL:  rdata_d = MSIX_IMPL ? msix_word : RD_ZERO;
                OFS_MSIX_TABLE: rdata_d = MSIX_IMPL ? tbl_word : RD_ZERO;
                OFS_MSIX_PBA:   rdata_d = MSIX_IMPL ? pba_word : RD_ZERO;
                OFS_DEV_CAPS:   rdata_d = dev_word;
                OFS_LINK_CAPS:  rdata_d = link_word;
                default:        rdata_d = RD_ZERO;   // unmapped reads return zero
            endcase
        end else if (cfg_req.valid && cfg_req.write) begin
            // only the enable, message enable and mask fields take writes; every fixed field keeps its setting
            case (dw_addr)
                OFS_MSI_CTRL: begin
                    // enable and message field share one lane, so one strobe moves both
                    if (cfg_req.be[MSI_CTRL_LANE]) begin
                        msi_en_d = cfg_req.wdata[MSI_EN_BIT];
                        // more messages than offered is clamped to the capable count
                        mme_d = (cfg_req.wdata[MSI_MME_LSB +: CODE_W] > mmc_code) ?
                                mmc_code : cfg_req.wdata[MSI_MME_LSB +: CODE_W];
                    end
                end
                OFS_MSIX_CTRL: begin
                    if (MSIX_IMPL && cfg_req.be[MSIX_CTRL_LANE]) begin
                        msix_en_d = cfg_req.wdata[MSIX_EN_BIT];
                        fmask_d   = cfg_req.wdata[MSIX_FMASK_BIT];
                    end
                end
                default: begin
                    // writes to read-only or unmapped dwords are dropped
                end
            endcase
        end
    end

    // control group: software enables and masks; reset leaves msi and msi-x off
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            msi_en_q  <= 1'b0;
            mme_q     <= 3'h0;
            msix_en_q <= 1'b0;
            fmask_q   <= 1'b0;
        end else begin
            msi_en_q  <= msi_en_d;
            mme_q     <= mme_d;
            msix_en_q <= msix_en_d;
            fmask_q   <= fmask_d;
        end
    end

    // read port group: data holds until the next read, the strobe lasts one cycle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q  <= RD_ZERO;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // pin group: the code is constant but kept in a flop so the output is registered;
    // it reads none during reset so no pin is claimed before the function runs
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_q <= INTX_NONE;
        end else begin
            pin_q <= pin_d;
        end
    end

    // outputs straight from the flops, so the link side never sees decode glitches
    assign cfg_rdata   = rdata_q;
    assign cfg_rvalid  = rvalid_q;
    assign msi_enable  = msi_en_q;
    assign msi_mme     = mme_q;
    assign msix_enable = msix_en_q;
    assign msix_fmask  = fmask_q;
    assign intx_pin    = pin_q;

endmodule : pcie_capability_config_regs
`default_nettype wire

// >>> bench/cap_cfg_asserts.sv
// bound checker for the capability configuration registers
`timescale 1ns/1ps
`default_nettype none
module cap_cfg_asserts
    import pcie_cap_cfg_pkg::*;
#(
    parameter logic       ROOT_PORT        = 1'b0,  // root port build
    parameter logic       FLR_ENABLE       = 1'b0,  // reset option
    parameter logic       DLL_ACTIVE_EN    = 1'b0,  // link active option
    parameter logic       SURPRISE_DOWN_EN = 1'b0,  // surprise option
    parameter logic [4:0] MSI_MESSAGES     = 5'd1,  // message count
    parameter intx_sel_t  INTX_SEL         = INTX_A // legacy choice
) (
    input wire logic        core_clk,    // clock
    input wire logic        arst_n,      // reset, active low
    input wire cfg_req_t    cfg_req,     // request
    input wire logic [31:0] cfg_rdata,   // read data
    input wire logic        cfg_rvalid,  // read valid
    input wire logic        msi_enable,  // msi on
    input wire logic [2:0]  msi_mme,     // msi enabled code
    input wire logic        msix_enable, // msi-x on
    input wire logic        msix_fmask,  // msi-x mask
    input wire logic [2:0]  intx_pin     // legacy pin
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic       rd; // read taken at this edge
    logic [9:0] dw; // dword index, low address bits ignored
    assign rd = cfg_req.valid && !cfg_req.write;
    assign dw = cfg_req.addr[11:2];
    a_read_answer: assert property (rd |=> cfg_rvalid) else $error("read not answered");
    a_no_stray: assert property (!rd |=> !cfg_rvalid) else $error("stray read valid");
    a_flr_bit: assert property (rd && dw == OFS_DEV_CAPS[11:2] |=>
        cfg_rdata[FLR_CAP_BIT] == (FLR_ENABLE && !ROOT_PORT)) else $error("reset capable bit wrong");
    a_link_bits: assert property (rd && dw == OFS_LINK_CAPS[11:2] |=>
        cfg_rdata[20:19] == ({DLL_ACTIVE_EN, SURPRISE_DOWN_EN} & {2{ROOT_PORT}})) else $error("link bits wrong");
    a_msi_capable: assert property (rd && dw == OFS_MSI_CTRL[11:2] |=>
        cfg_rdata[19:17] == 3'($clog2(MSI_MESSAGES))) else $error("msi capable field wrong");
    a_bir_legal: assert property (rd && (dw == OFS_MSIX_TABLE[11:2] || dw == OFS_MSIX_PBA[11:2]) |=>
        cfg_rdata[2:0] <= BIR_MAX) else $error("bar indicator out of range");
    a_intx_fixed: assert property ($past(arst_n) |-> intx_pin == INTX_SEL) else $error("legacy pin wrong");
    // controls move only on a write, so nothing fixed can drift
    a_ctrl_hold: assert property (!(cfg_req.valid && cfg_req.write) |=>
        $stable({msi_enable, msi_mme, msix_enable, msix_fmask})) else $error("control moved without write");
    c_pba_read: cover property (rd && dw == OFS_MSIX_PBA[11:2]);
    c_msi_on: cover property ($rose(msi_enable));
    c_msix_on: cover property ($rose(msix_enable));
endmodule : cap_cfg_asserts
bind pcie_capability_config_regs cap_cfg_asserts #(.ROOT_PORT(ROOT_PORT), .FLR_ENABLE(FLR_ENABLE),
    .DLL_ACTIVE_EN(DLL_ACTIVE_EN), .SURPRISE_DOWN_EN(SURPRISE_DOWN_EN), .MSI_MESSAGES(MSI_MESSAGES),
    .INTX_SEL(INTX_SEL)) cap_cfg_asserts_inst (.core_clk(core_clk), .arst_n(arst_n), .cfg_req(cfg_req),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .msi_enable(msi_enable), .msi_mme(msi_mme),
    .msix_enable(msix_enable), .msix_fmask(msix_fmask), .intx_pin(intx_pin));
`default_nettype wire

// >>> bench/cfg_host_model.sv
// host model issuing configuration reads and writes
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model
    import pcie_cap_cfg_pkg::*;
(
    input  wire logic        core_clk,  // clock
    output var  cfg_req_t    cfg_req,   // request to the function
    input  wire logic [31:0] cfg_rdata, // read data
    input  wire logic        cfg_rvalid // read valid
);
    initial cfg_req = '0; // idle until the first transfer
    // one dword, held for one rising edge, answer taken a cycle later
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] d);
        @(negedge core_clk);
        cfg_req = {1'b1, wr, a, be, wd};
        @(negedge core_clk);
        d = cfg_rvalid ? cfg_rdata : 32'hxxxx_xxxx; // a missing answer never matches
        cfg_req = {1'b0, ~cfg_req[47:0]}; // released address, enable and data lines must not keep the old value; valid and write drop to 0
    endtask : xfer
endmodule : cfg_host_model
`default_nettype wire

// >>> bench/pcie_capability_config_regs_tb_top.sv
// testbench for the capability configuration registers
`timescale 1ns/1ps
`default_nettype none
module pcie_capability_config_regs_tb_top
    import pcie_cap_cfg_pkg::*;
;
    logic        core_clk, arst_n;       // clock and reset
    cfg_req_t    cfg_req;                // shared host request
    logic [31:0] cfg_rdata, root_rdata;  // endpoint and root port read data
    logic        cfg_rvalid, msi_enable, msix_enable, msix_fmask; // endpoint status
    logic [2:0]  msi_mme, intx_pin;      // endpoint codes
    logic [2:0]  root_mme;               // root port messages enabled
    logic        root_msix_en;           // root port msi-x enable
    // build settings of the two functions under test
    localparam logic        EP_FLR      = 1'b1;          // endpoint reset option
    localparam logic        EP_DLL      = 1'b0;          // upstream port: reporting off
    localparam logic        EP_SDN      = 1'b1;          // ignored on an endpoint
    localparam logic [4:0]  EP_MSI_N    = 5'h08;         // eight messages requested
    localparam logic        EP_MSIX     = 1'b1;          // msi-x built in
    localparam logic [10:0] EP_TBL_SIZE = 11'h7ff;       // largest table
    localparam logic [31:0] EP_TBL_OFS  = 32'h0000_1237; // low bits must read as the indicator
    localparam logic [2:0]  EP_TBL_BIR  = 3'h5;          // last legal bar
    localparam logic [31:0] EP_PBA_OFS  = 32'h0000_2cc6; // low bits must read as the indicator
    localparam logic [2:0]  EP_PBA_BIR  = 3'h4;          // pending array bar
    localparam intx_sel_t   EP_INTX     = INTX_C;        // legacy interrupt c
    localparam logic        RP_ROOT     = 1'b1;          // second function is a root port
    localparam logic        RP_DLL      = 1'b1;          // hot-plug downstream: reporting on
    logic [31:0] d;                      // last read value
    int          bad_count, tests_run;   // tallies
    // endpoint: upstream port, so link active reporting is off
    pcie_capability_config_regs #(.FLR_ENABLE(EP_FLR), .DLL_ACTIVE_EN(EP_DLL), .SURPRISE_DOWN_EN(EP_SDN),
        .MSI_MESSAGES(EP_MSI_N), .MSIX_IMPL(EP_MSIX), .MSIX_TABLE_SIZE(EP_TBL_SIZE), .MSIX_TABLE_OFS(EP_TBL_OFS),
        .MSIX_TABLE_BIR(EP_TBL_BIR), .MSIX_PBA_OFS(EP_PBA_OFS), .MSIX_PBA_BIR(EP_PBA_BIR), .INTX_SEL(EP_INTX))
    pcie_capability_config_regs_inst (.core_clk(core_clk), .arst_n(arst_n), .cfg_req(cfg_req),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .msi_enable(msi_enable), .msi_mme(msi_mme),
        .msix_enable(msix_enable), .msix_fmask(msix_fmask), .intx_pin(intx_pin));
    // root port: hot-plug downstream port, so link active reporting is on
    pcie_capability_config_regs #(.ROOT_PORT(RP_ROOT), .FLR_ENABLE(EP_FLR), .DLL_ACTIVE_EN(RP_DLL),
        .SURPRISE_DOWN_EN(EP_SDN)) root_regs_inst (.core_clk(core_clk), .arst_n(arst_n), .cfg_req(cfg_req),
        .cfg_rdata(root_rdata), .cfg_rvalid(), .msi_enable(), .msi_mme(root_mme), .msix_enable(root_msix_en),
        .msix_fmask(), .intx_pin());
    cfg_host_model cfg_host_model_inst (.core_clk(core_clk), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rd(input logic [11:0] a);
        cfg_host_model_inst.xfer(1'b0, a, 4'hf, 32'h0000_0000, d);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] v);
        cfg_host_model_inst.xfer(1'b1, a, be, v, d);
    endtask : wr
    task automatic test_caps;
        rd(OFS_DEV_CAPS);
        chk("flr endpoint", 32'h1, 32'(d[28]));
        chk("flr root", 32'h0, 32'(root_rdata[28]));
        rd(OFS_LINK_CAPS);
        chk("link endpoint", 32'h0, 32'(d[20:19]));
        chk("link root", 32'h3, 32'(root_rdata[20:19]));
        $display("test caps done");
    endtask : test_caps
    task automatic test_msi;
        rd(OFS_MSI_CTRL);
        chk("msi capable", 32'h3, 32'(d[19:17]));
        chk("msi capable root", 32'h0, 32'(root_rdata[19:17]));
        wr(OFS_MSI_CTRL, 4'h4, 32'h0031_0000);
        chk("msi on", 32'h31, {25'h0, msi_mme, 3'h0, msi_enable});
        chk("mme clamp root", 32'h0, 32'(root_mme));
        wr(OFS_MSI_CTRL, 4'hb, 32'h0000_0000);
        rd(OFS_MSI_CTRL);
        chk("msi reg", 32'h0037_0005, d);
        wr(OFS_MSI_CTRL, 4'h4, 32'h0070_0000);
        chk("mme clamp", 32'h30, {25'h0, msi_mme, 3'h0, msi_enable});
        $display("test msi done");
    endtask : test_msi
    task automatic test_msix;
        rd(OFS_MSIX_CTRL);
        chk("table size", 32'h7ff, 32'(d[26:16]));
        chk("msix absent", 32'h0, root_rdata);
        rd(OFS_MSIX_TABLE);
        chk("table loc", 32'h0000_1235, d);
        rd(OFS_MSIX_PBA);
        chk("pba loc", 32'h0000_2cc4, d);
        wr(OFS_MSIX_TABLE, 4'hf, 32'hffff_ffff);
        rd(OFS_MSIX_TABLE);
        chk("table kept", 32'h0000_1235, d);
        wr(OFS_MSIX_CTRL, 4'h8, 32'hc000_0000);
        chk("msix on", 32'h3, {30'h0, msix_enable, msix_fmask});
        chk("msix root off", 32'h0, 32'(root_msix_en));
        wr(OFS_MSIX_CTRL, 4'h7, 32'h0000_0000);
        chk("msix lane off", 32'h3, {30'h0, msix_enable, msix_fmask});
        $display("test msix done");
    endtask : test_msix
    task automatic test_intx;
        chk("pin out", 32'h3, 32'(intx_pin));
        rd(OFS_INTX_LINE);
        chk("pin reg", 32'h3, 32'(d[15:8]));
        chk("pin root", 32'h1, 32'(root_rdata[15:8]));
        rd(12'h200);
        chk("unmapped", 32'h0, d);
        $display("test intx done");
    endtask : test_intx
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test
    // watchdog: the whole sequence needs under two microseconds
    initial begin
        #20000;
        bad_count++;
        finish_test();
    end
    initial begin
        bad_count = 0;
        tests_run = 0;
        arst_n = 1'b0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        arst_n = 1'b1;
        test_caps();
        test_msi();
        test_msix();
        test_intx();
        finish_test();
    end
endmodule : pcie_capability_config_regs_tb_top
`default_nettype wire
